// ### include/csd_defs.svh
/*
 * Register offsets, field positions, reset values and counts of the
 * clock select and divider block.
 * Assumes inclusion by bare name from the include folder.
 */
`ifndef CSD_DEFS_SVH
`define CSD_DEFS_SVH

// ==========================================================================
// Register offsets
`define CSD_ADDR_HF_TRIM 8'hC7
`define CSD_ADDR_LF_CTRL 8'hB1
`define CSD_ADDR_CLK_SEL 8'hA9
`define CSD_ADDR_T3_CTRL 8'h91
`define CSD_ADDR_T3_RLD_LO 8'h92
`define CSD_ADDR_T3_RLD_HI 8'h93
`define CSD_ADDR_T3_CNT_LO 8'h94
`define CSD_ADDR_T3_CNT_HI 8'h95

// ==========================================================================
// Field positions
`define CSD_SRC_LSB 0
`define CSD_SRC_MSB 1
`define CSD_DIV_LSB 4
`define CSD_DIV_MSB 6
`define CSD_LF_DIV_LSB 0
`define CSD_LF_DIV_MSB 1
`define CSD_LF_TRIM_LSB 2
`define CSD_LF_TRIM_MSB 5
`define CSD_LF_RDY_BIT 6
`define CSD_LF_EN_BIT 7
`define CSD_T3_RUN_BIT 0
`define CSD_T3_CAPT_BIT 1

// ==========================================================================
// Reset values and counts
`define CSD_DIV_RST 3'h3
`define CSD_HF_TRIM_RST 8'h80
`define CSD_LF_TRIM_RST 4'h0
`define CSD_LF_DIV_RST 2'h0
`define CSD_LF_SETTLE_TICKS 4'h8

`endif

// ### include/csd_pkg.sv
/*
 * Types of the clock select and divider block.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package csd_pkg;

    // ======================================================================
    // Clock source codes and low-frequency oscillator start-up states
    typedef enum logic [1:0] {
        CSD_SRC_HF = 2'b00,
        CSD_SRC_EXT = 2'b01,
        CSD_SRC_LF = 2'b10,
        CSD_SRC_RSVD = 2'b11
    } csd_src_t;

    typedef enum logic [1:0] {
        CSD_LF_OFF = 2'b00,
        CSD_LF_SETTLE = 2'b01,
        CSD_LF_READY = 2'b10
    } csd_lf_state_t;

endpackage : csd_pkg

// ### core/csd_pin_sync.sv
/*
 * Three-stage pin synchroniser with a rising-edge pulse.
 * Assumes pin_in is asynchronous to clk.
 */
`timescale 1ns/1ps
module csd_pin_sync (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Pin and result
    input wire logic pin_in,
    output logic level,
    output logic rise
);
    // ======================================================================
    // Synchroniser
    logic s1_r;
    logic s2_r;
    logic s3_r;
    logic lvl_r;
    logic lvl_nxt;

    // A change counts only once the second and third stage agree.
    assign lvl_nxt = (s2_r == s3_r) ? s3_r : lvl_r;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s1_r <= 1'b0;
            s2_r <= 1'b0;
            s3_r <= 1'b0;
            lvl_r <= 1'b0;
        end else begin
            s1_r <= pin_in;
            s2_r <= s1_r;
            s3_r <= s2_r;
            lvl_r <= lvl_nxt;
        end
    end

    assign level = lvl_r;
    assign rise = lvl_nxt & ~lvl_r;
endmodule : csd_pin_sync

// ### core/csd_pow2_div.sv
/*
 * Power-of-two divider of a tick stream: one output tick per 2**shift
 * input ticks.
 * Assumes tick_in is a one-cycle enable on clk.
 */
`timescale 1ns/1ps
module csd_pow2_div #(
    parameter int SHIFT_W = 3
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Control
    input wire logic [SHIFT_W-1:0] shift,
    input wire logic restart,
    // Ticks
    input wire logic tick_in,
    output logic tick_out
);
    localparam int CNT_W = (1 << SHIFT_W) - 1;

    // ======================================================================
    // Counter
    logic [CNT_W-1:0] cnt_r;
    logic [CNT_W-1:0] cnt_nxt;
    logic [CNT_W-1:0] mask;
    logic hit;

    assign mask = ~({CNT_W{1'b1}} << shift);
    assign hit = (cnt_r & mask) == mask;
    assign tick_out = tick_in & hit & ~restart;
    // Restart starts a fresh period so a new factor never yields a short one.
    assign cnt_nxt = restart ? {CNT_W{1'b0}} : (tick_in ? cnt_r + 1'b1 : cnt_r);

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_r <= {CNT_W{1'b0}};
        end else begin
            cnt_r <= cnt_nxt;
        end
    end
endmodule : csd_pow2_div

// ### core/csd_top.sv
/*
 * Clock source select and divider: picks the high-frequency, low-frequency
 * or external source, post-divides it into the system clock enable,
 * resynchronises the external pin and captures timer three on
 * low-frequency edges.
 * Assumes oscillator ticks are one-cycle enables on sys_clk and that
 * the external pin is asynchronous.
 */
//
// Overview of operation
// R1 - Three sources: HF, LF, external pin.
// R2 - Power-of-two post divider, up to 128.
// R3 - Reset selects HF divided by eight.
// R4 - HF oscillator runs whenever requested.
// R5 - HF trim register sets oscillator period.
// R6 - LF output divided by 1, 2, 4, 8.
// R7 - LF trim field adjusts LF frequency.
// R8 - LF rising edge captures timer three.
// R9 - Capture copies count into reload.
// R10 - Software calibrates LF from captures.
// R11 - External clock may clock peripherals.
// R12 - External clock resynchronised when not selected.
// R13 - External source only for code 01.
// R14 - Source switch on the fly, no reset.
// R15 - Divider change accepted any time.
// R16 - Internal oscillators selectable right after enable.
// R17 - Software skips pin, sets digital input.
// R18 - Software checks external clock before switching.
// R19 - Divider codes 000..111 give 1..128.
// R20 - LF select 00=8, 01=4, 10=2, 11=1.
// R21 - LF ready flag reads settled state.
// R22 - Watchdog forces LF oscillator on.
// R23 - Switching never makes short clock pulses.
// R24 - External pin synchronised, edges give enables.
`timescale 1ns/1ps
`include "csd_defs.svh"
module csd_top
    import csd_pkg::*;
(
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst_n,
    // Register port
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    // High-frequency oscillator
    input wire logic hf_osc_tick,
    input wire logic hf_consumer_req,
    output logic hf_osc_run,
    output logic [7:0] hf_trim,
    // Low-frequency oscillator
    input wire logic lf_osc_tick,
    input wire logic wdt_active,
    output logic lf_osc_run,
    output logic [3:0] lf_trim,
    // External clock pin
    input wire logic external_clock_pin,
    // Clock enables out
    output logic system_clock_en,
    output logic ext_periph_en,
    output logic lf_out_tick
);
    // ======================================================================
    // Register decode
    logic wr_hf_trim;
    logic wr_lf_ctrl;
    logic wr_clk_sel;
    logic wr_t3_ctrl;
    logic wr_rld_lo;
    logic wr_rld_hi;
    logic wr_cnt_lo;
    logic wr_cnt_hi;

    assign wr_hf_trim = reg_wr && (reg_addr == `CSD_ADDR_HF_TRIM);
    assign wr_lf_ctrl = reg_wr && (reg_addr == `CSD_ADDR_LF_CTRL);
    assign wr_clk_sel = reg_wr && (reg_addr == `CSD_ADDR_CLK_SEL);
    assign wr_t3_ctrl = reg_wr && (reg_addr == `CSD_ADDR_T3_CTRL);
    assign wr_rld_lo = reg_wr && (reg_addr == `CSD_ADDR_T3_RLD_LO);
    assign wr_rld_hi = reg_wr && (reg_addr == `CSD_ADDR_T3_RLD_HI);
    assign wr_cnt_lo = reg_wr && (reg_addr == `CSD_ADDR_T3_CNT_LO);
    assign wr_cnt_hi = reg_wr && (reg_addr == `CSD_ADDR_T3_CNT_HI);

    // ======================================================================
    // Configuration registers
    logic [7:0] hf_trim_r;
    logic lf_en_r;
    logic [3:0] lf_trim_r;
    logic [1:0] lf_div_sel_r;
    logic [2:0] clk_div_r;
    csd_src_t clk_src_r;
    logic t3_run_r;
    logic t3_capt_r;
    logic clk_restart;

    // Reserved bits of the select register are ignored on write.
    assign clk_restart = wr_clk_sel;

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            hf_trim_r <= `CSD_HF_TRIM_RST; // R5
            lf_en_r <= 1'b0;
            lf_trim_r <= `CSD_LF_TRIM_RST;
            lf_div_sel_r <= `CSD_LF_DIV_RST;
            clk_div_r <= `CSD_DIV_RST; // R3
            clk_src_r <= CSD_SRC_HF; // R3
            t3_run_r <= 1'b0;
            t3_capt_r <= 1'b0;
        end else begin
            if (wr_hf_trim) begin
                hf_trim_r <= reg_wdata; // R5
            end
            if (wr_lf_ctrl) begin
                lf_en_r <= reg_wdata[`CSD_LF_EN_BIT];
                lf_trim_r <= reg_wdata[`CSD_LF_TRIM_MSB:`CSD_LF_TRIM_LSB]; // R7
                lf_div_sel_r <= reg_wdata[`CSD_LF_DIV_MSB:`CSD_LF_DIV_LSB];
            end
            if (wr_clk_sel) begin
                clk_div_r <= reg_wdata[`CSD_DIV_MSB:`CSD_DIV_LSB]; // R15
                clk_src_r <= csd_src_t'(reg_wdata[`CSD_SRC_MSB:`CSD_SRC_LSB]); // R14 R16
            end
            if (wr_t3_ctrl) begin
                t3_run_r <= reg_wdata[`CSD_T3_RUN_BIT];
                t3_capt_r <= reg_wdata[`CSD_T3_CAPT_BIT];
            end
        end
    end

    assign hf_trim = hf_trim_r;
    assign lf_trim = lf_trim_r; // R7

    // ======================================================================
    // Oscillator enables and low-frequency start-up
    csd_lf_state_t lf_state_r;
    csd_lf_state_t lf_state_nxt;
    logic [3:0] lf_settle_r;
    logic [3:0] lf_settle_nxt;
    logic lf_rdy;
    logic lf_tick_g;

    assign hf_osc_run = (clk_src_r == CSD_SRC_HF) || (clk_src_r == CSD_SRC_RSVD)
                        || hf_consumer_req; // R4
    assign lf_osc_run = lf_en_r || wdt_active; // R22
    assign lf_tick_g = lf_osc_tick && lf_osc_run;
    assign lf_rdy = (lf_state_r == CSD_LF_READY); // R21

    always_comb begin
        lf_state_nxt = lf_state_r;
        lf_settle_nxt = lf_settle_r;
        case (lf_state_r)
            CSD_LF_OFF: begin
                lf_settle_nxt = 4'h0;
                if (lf_osc_run) begin
                    lf_state_nxt = CSD_LF_SETTLE;
                end
            end
            CSD_LF_SETTLE: begin
                if (lf_tick_g) begin
                    lf_settle_nxt = lf_settle_r + 4'h1;
                end
                if (lf_settle_nxt == `CSD_LF_SETTLE_TICKS) begin
                    lf_state_nxt = CSD_LF_READY;
                end
            end
            CSD_LF_READY: begin
                lf_state_nxt = CSD_LF_READY;
            end
            default: begin
                lf_state_nxt = CSD_LF_OFF;
            end
        endcase
        if (!lf_osc_run) begin
            lf_state_nxt = CSD_LF_OFF; // R21
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            lf_state_r <= CSD_LF_OFF;
            lf_settle_r <= 4'h0;
        end else begin
            lf_state_r <= lf_state_nxt;
            lf_settle_r <= lf_settle_nxt;
        end
    end

    // ======================================================================
    // Low-frequency output divider
    logic lf_div_tick;

    // Select code 00 divides by 8 and 11 by 1, so the shift is the inverse.
    csd_pow2_div #(.SHIFT_W(2)) u_lf_div (
        .clk(sys_clk),
        .rst_n(rst_n),
        .shift(~lf_div_sel_r), // R20
        .restart(wr_lf_ctrl),
        .tick_in(lf_tick_g),
        .tick_out(lf_div_tick) // R6
    );

    // ======================================================================
    // External pin synchroniser
    logic ext_rise;

    csd_pin_sync u_ext_sync (
        .clk(sys_clk),
        .rst_n(rst_n),
        .pin_in(external_clock_pin),
        .level(),
        .rise(ext_rise) // R24
    );

    // ======================================================================
    // Source select and system divider
    logic src_tick;
    logic sys_tick;

    // Every source arrives as an enable on sys_clk, so switching between
    // them cannot produce a runt pulse; the divider restarts on each write.
    assign src_tick = (clk_src_r == CSD_SRC_EXT) ? ext_rise : // R13
                      (clk_src_r == CSD_SRC_LF) ? lf_div_tick : hf_osc_tick; // R1

    csd_pow2_div #(.SHIFT_W(3)) u_sys_div (
        .clk(sys_clk),
        .rst_n(rst_n),
        .shift(clk_div_r), // R19
        .restart(clk_restart), // R23
        .tick_in(src_tick),
        .tick_out(sys_tick) // R2
    );

    // ======================================================================
    // Timer three with low-frequency capture
    logic [15:0] t3_cnt_r;
    logic [15:0] t3_rld_r;
    logic t3_capture;

    assign t3_capture = t3_capt_r && lf_div_tick; // R8

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            t3_cnt_r <= 16'h0000;
            t3_rld_r <= 16'h0000;
        end else begin
            if (wr_cnt_lo) begin
                t3_cnt_r[7:0] <= reg_wdata;
            end else if (wr_cnt_hi) begin
                t3_cnt_r[15:8] <= reg_wdata;
            end else if (t3_run_r && sys_tick) begin
                t3_cnt_r <= t3_cnt_r + 16'h0001;
            end
            // A capture wins over a software reload write in the same cycle.
            if (t3_capture) begin
                t3_rld_r <= t3_cnt_r; // R9
            end else if (wr_rld_lo) begin
                t3_rld_r[7:0] <= reg_wdata;
            end else if (wr_rld_hi) begin
                t3_rld_r[15:8] <= reg_wdata;
            end
        end
    end

    // ======================================================================
    // Read path and registered outputs
    logic [7:0] rd_mux;
    logic [7:0] rdata_r;
    logic system_clock_en_r;
    logic ext_en_r;
    logic lf_out_r;

    assign rd_mux =
        (reg_addr == `CSD_ADDR_HF_TRIM) ? hf_trim_r :
        (reg_addr == `CSD_ADDR_LF_CTRL) ? {lf_en_r, lf_rdy, lf_trim_r, lf_div_sel_r} :
        (reg_addr == `CSD_ADDR_CLK_SEL) ? {1'b0, clk_div_r, 2'b00, clk_src_r} :
        (reg_addr == `CSD_ADDR_T3_CTRL) ? {6'h00, t3_capt_r, t3_run_r} :
        (reg_addr == `CSD_ADDR_T3_RLD_LO) ? t3_rld_r[7:0] :
        (reg_addr == `CSD_ADDR_T3_RLD_HI) ? t3_rld_r[15:8] :
        (reg_addr == `CSD_ADDR_T3_CNT_LO) ? t3_cnt_r[7:0] :
        (reg_addr == `CSD_ADDR_T3_CNT_HI) ? t3_cnt_r[15:8] : 8'h00;

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            rdata_r <= 8'h00;
            system_clock_en_r <= 1'b0;
            ext_en_r <= 1'b0;
            lf_out_r <= 1'b0;
        end else begin
            rdata_r <= reg_rd ? rd_mux : 8'h00;
            system_clock_en_r <= sys_tick;
            ext_en_r <= ext_rise; // R11 R12
            lf_out_r <= lf_div_tick;
        end
    end

    assign reg_rdata = rdata_r;
    assign system_clock_en = system_clock_en_r;
    assign ext_periph_en = ext_en_r;
    assign lf_out_tick = lf_out_r;

    // ======================================================================
    // Assertions
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);

    logic [7:0] src_gap_r;

    // Counts source ticks since the last output tick or restart.
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            src_gap_r <= 8'h00;
        end else if (clk_restart || sys_tick) begin
            src_gap_r <= 8'h00;
        end else if (src_tick) begin
            src_gap_r <= src_gap_r + 8'h01;
        end
    end

    AST_RESET_DEFAULT: assert property ($rose(rst_n) |-> // R3
        clk_div_r == 3'h3 && clk_src_r == CSD_SRC_HF)
        else $error("reset did not select HF divided by eight");
    AST_DIV_FACTOR: assert property (sys_tick |-> // R19
        ({1'b0, src_gap_r} + 9'h001) == (9'h001 << clk_div_r))
        else $error("system divider period wrong");
    AST_EXT_ONLY_01: assert property (system_clock_en && $past(clk_src_r) == CSD_SRC_EXT // R13
        && !$past(clk_restart) |-> $past(ext_rise))
        else $error("external source used without its edge");
    AST_SYNC_DELAY: assert property ($rose(external_clock_pin) |-> // R24
        !ext_rise ##1 !ext_rise)
        else $error("external edge passed synchroniser too fast");
    AST_LF_DIV1: assert property (lf_div_sel_r == 2'b11 && lf_tick_g && !wr_lf_ctrl // R20
        |=> lf_out_tick)
        else $error("LF divide by one dropped a tick");
    AST_HF_AUTO: assert property (wr_clk_sel && reg_wdata[1:0] == 2'b00 |=> // R4
        hf_osc_run)
        else $error("HF oscillator not enabled on selection");
    AST_LF_WDT: assert property (wdt_active |-> lf_osc_run) // R22
        else $error("watchdog did not force LF oscillator");
    AST_RDY_OFF: assert property (!lf_osc_run |=> !lf_rdy) // R21
        else $error("ready flag set while LF oscillator off");
    AST_CAPTURE: assert property (t3_capture |=> t3_rld_r == $past(t3_cnt_r)) // R9
        else $error("capture did not copy timer count");
    AST_TRIM_WRITE: assert property (wr_hf_trim |=> hf_trim == $past(reg_wdata)) // R5
        else $error("HF trim write lost");
    AST_SWITCH: assert property (wr_clk_sel |=> // R14
        clk_src_r == $past(reg_wdata[1:0]) && clk_div_r == $past(reg_wdata[6:4]))
        else $error("clock select write not taken");

    COV_EXT_SRC: cover property (clk_src_r == CSD_SRC_EXT ##1 system_clock_en);
    COV_LF_READY: cover property ($rose(lf_rdy));
    COV_CAPTURE: cover property (t3_capture ##[1:200] t3_capture);
endmodule : csd_top

// ### dv/csd_ext_clk_src.sv
/*
 * Behavioural external CMOS clock source that drives the clock pin.
 * Assumes the bench starts and stops it; while stopped it drives low.
 */
`timescale 1ns/1ps
module csd_ext_clk_src #(
    parameter real HALF_NS = 43.7
) (
    // Control
    input wire logic run,
    // Pin and edge count
    output logic clk_pin,
    output int rise_count
);
    // ======================================================================
    // Free-running source
    // Each phase spans more than two system clock periods, so the pin filter,
    // which wants two agreeing samples, sees every edge.
    initial begin
        clk_pin = 1'b0;
        rise_count = 0;
    end

    // A stop only takes effect after the high phase ends, so no runt pulse is made.
    always begin
        #(HALF_NS);
        if (run || clk_pin) begin
            clk_pin = ~clk_pin;
            rise_count = rise_count + (clk_pin ? 1 : 0);
        end
    end
endmodule : csd_ext_clk_src

// ### dv/system_clock_select_divider_tb.sv
/*
 * Self-checking bench of the clock select and divider block.
 * Assumes csd_defs.svh on the include path and the external source model.
 */
`timescale 1ns/1ps
`include "csd_defs.svh"
module system_clock_select_divider_tb;
    logic sys_clk = 1'b0;
    logic rst_n = 1'b0;
    logic [7:0] reg_addr = 8'h00;
    logic [7:0] reg_wdata = 8'h00;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [7:0] reg_rdata;
    logic hf_osc_tick = 1'b0;
    logic hf_consumer_req = 1'b0;
    logic hf_osc_run;
    logic [7:0] hf_trim;
    logic lf_osc_tick = 1'b0;
    logic wdt_active = 1'b0;
    logic lf_osc_run;
    logic [3:0] lf_trim;
    logic external_clock_pin;
    logic system_clock_en;
    logic ext_periph_en;
    logic lf_out_tick;
    logic ext_run = 1'b0;
    int ext_rises;
    int bad_count = 0;
    int checks = 0;
    int cycles = 0;
    int en_cnt = 0;
    int ext_cnt = 0;
    int hf_n;
    int lf_n;
    int gap [2] = '{0, 0};
    int exp_gap [2] = '{0, 0};
    bit arm [2] = '{0, 0};
    bit tick_sel = 1'b0;
    logic [7:0] rv;
    logic [15:0] cv;
    logic [3:0] trim;
    int x0;
    int e0;
    int r0;

    always #10 sys_clk = ~sys_clk;

    csd_top DUT (
        .sys_clk, .rst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
        .hf_osc_tick, .hf_consumer_req, .hf_osc_run, .hf_trim,
        .lf_osc_tick, .wdt_active, .lf_osc_run, .lf_trim,
        .external_clock_pin, .system_clock_en, .ext_periph_en, .lf_out_tick
    );

    csd_ext_clk_src u_src (.run(ext_run), .clk_pin(external_clock_pin), .rise_count(ext_rises));

    // ======================================================================
    // Expectations, checks and bus tasks
    function automatic logic [7:0] clock_select_register_val(input logic [2:0] d, input logic [1:0] s);
        return {1'b0, d, 2'b00, s};
    endfunction : clock_select_register_val

    task automatic compare(input logic [15:0] seen, input logic [15:0] want);
        checks++;
        if (seen !== want) begin
            bad_count++;
            $display("ERROR %0t ns: seen %h expected %h", $time, seen, want);
        end
    endtask : compare

    task automatic complete_run();
        $display("checks=%0d bad_count=%0d", checks, bad_count);
        if (bad_count == 0 && checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : complete_run

    // Two writes on consecutive edges, one system clock apart.
    task automatic wr_pair(input logic [7:0] a1, d1, a2, d2);
        reg_addr <= a1;
        reg_wdata <= d1;
        reg_wr <= 1'b1;
        @(posedge sys_clk);
        reg_addr <= a2;
        reg_wdata <= d2;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
        @(posedge sys_clk);
    endtask : wr_pair

    task automatic reg_write(input logic [7:0] a, d);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
        @(posedge sys_clk);
    endtask : reg_write

    task automatic reg_read(input logic [7:0] a, output logic [7:0] v);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        #1 v = reg_rdata;
        @(posedge sys_clk);
    endtask : reg_read

    task automatic run_ticks(input int cyc, input bit hf_on, input bit lf_on);
        hf_n = 0;
        lf_n = 0;
        repeat (cyc) begin
            hf_osc_tick <= hf_on && ($urandom % 3 != 0);
            lf_osc_tick <= lf_on && ($urandom % 2 != 0);
            @(posedge sys_clk);
            hf_n += hf_osc_tick;
            lf_n += lf_osc_tick;
        end
        hf_osc_tick <= 1'b0;
        lf_osc_tick <= 1'b0;
        repeat (8) @(posedge sys_clk);
    endtask : run_ticks

    // ======================================================================
    // Monitors: lane 0 counts source ticks between system enables, lane 1
    // raw low-frequency ticks between divided ticks; the first gap after
    // a change of settings is thrown away because the divider restarts.
    always @(negedge sys_clk) begin
        en_cnt += system_clock_en;
        ext_cnt += ext_periph_en;
        for (int i = 0; i < 2; i++) begin
            if ((i == 0 ? system_clock_en : lf_out_tick) === 1'b1) begin
                if (arm[i] && exp_gap[i] != 0) begin
                    compare(gap[i], exp_gap[i]);
                end
                arm[i] = 1'b1;
                gap[i] = 0;
            end
            gap[i] += (i == 0) ? (tick_sel ? lf_out_tick : hf_osc_tick) : lf_osc_tick;
        end
    end

    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 20000) begin
            bad_count++;
            complete_run();
        end
    end

    // ======================================================================
    // Main sequence
    initial begin
        x0 = $urandom(32'h8D96);
        repeat (6) @(posedge sys_clk);
        rst_n <= 1'b1;
        @(posedge sys_clk);
        compare(hf_osc_run, 1'b1);
        compare(hf_trim, `CSD_HF_TRIM_RST);
        reg_read(`CSD_ADDR_CLK_SEL, rv);
        compare(rv, clock_select_register_val(3'h3, 2'b00));
        reg_read(`CSD_ADDR_HF_TRIM, rv);
        compare(rv, `CSD_HF_TRIM_RST);
        reg_read(8'h00, rv);
        compare(rv, 8'h00);
        cv = 16'($urandom);
        reg_write(`CSD_ADDR_HF_TRIM, cv[7:0]);
        compare(hf_trim, cv[7:0]);
        // External pin clocks peripherals while the system runs from HF.
        x0 = ext_cnt;
        e0 = en_cnt;
        r0 = ext_rises;
        ext_run <= 1'b1;
        repeat (400) @(posedge sys_clk);
        ext_run <= 1'b0;
        repeat (20) @(posedge sys_clk);
        compare(16'(ext_cnt - x0), 16'(ext_rises - r0));
        compare(16'(en_cnt - e0), 16'h0000);
        reg_write(`CSD_ADDR_CLK_SEL, clock_select_register_val(3'h0, 2'b01));
        e0 = en_cnt;
        r0 = ext_rises;
        ext_run <= 1'b1;
        repeat (400) @(posedge sys_clk);
        ext_run <= 1'b0;
        repeat (20) @(posedge sys_clk);
        compare(16'(en_cnt - e0), 16'(ext_rises - r0));
        // Every divider code, with the reserved source code standing for HF on the odd codes.
        for (int d = 0; d < 8; d++) begin
            exp_gap[0] = 0;
            reg_write(`CSD_ADDR_CLK_SEL, clock_select_register_val(d[2:0], d[0] ? 2'b11 : 2'b00));
            reg_read(`CSD_ADDR_CLK_SEL, rv);
            compare(rv, clock_select_register_val(d[2:0], d[0] ? 2'b11 : 2'b00));
            arm = '{0, 0};
            exp_gap[0] = 1 << d;
            run_ticks((6 << d) + 20, 1'b1, 1'b0);
        end
        // LF selected in the write right after the one that enables it.
        exp_gap[0] = 0;
        trim = 4'($urandom);
        wr_pair(`CSD_ADDR_LF_CTRL, {2'b10, trim, 2'b11}, `CSD_ADDR_CLK_SEL,
                clock_select_register_val(3'h0, 2'b10));
        hf_consumer_req <= 1'b1;
        reg_read(`CSD_ADDR_LF_CTRL, rv);
        compare(rv, {2'b10, trim, 2'b11});
        compare(hf_osc_run, 1'b1);
        compare(lf_trim, trim);
        tick_sel = 1'b1;
        arm = '{0, 0};
        exp_gap[0] = 1;
        run_ticks(40, 1'b1, 1'b1);
        reg_read(`CSD_ADDR_LF_CTRL, rv);
        compare(rv, {1'b1, lf_n >= 8, trim, 2'b11});
        for (int c = 0; c < 4; c++) begin
            reg_write(`CSD_ADDR_LF_CTRL, {2'b10, trim, c[1:0]});
            arm = '{0, 0};
            exp_gap[1] = 8 >> c;
            run_ticks(90, 1'b1, 1'b1);
        end
        exp_gap = '{0, 0};
        tick_sel = 1'b0;
        // Capture copies the count only in capture mode.
        reg_write(`CSD_ADDR_LF_CTRL, {2'b10, trim, 2'b11});
        reg_write(`CSD_ADDR_CLK_SEL, clock_select_register_val(3'h0, 2'b00));
        reg_write(`CSD_ADDR_T3_CTRL, 8'h00);
        cv = 16'($urandom);
        reg_write(`CSD_ADDR_T3_CNT_LO, cv[7:0]);
        reg_write(`CSD_ADDR_T3_CNT_HI, cv[15:8]);
        reg_write(`CSD_ADDR_T3_RLD_LO, ~cv[7:0]);
        reg_write(`CSD_ADDR_T3_RLD_HI, ~cv[15:8]);
        run_ticks(20, 1'b0, 1'b1);
        reg_read(`CSD_ADDR_T3_RLD_LO, rv);
        compare(rv, {8'h00, ~cv[7:0]});
        reg_write(`CSD_ADDR_T3_CTRL, 8'h02);
        run_ticks(20, 1'b0, 1'b1);
        reg_read(`CSD_ADDR_T3_RLD_LO, rv);
        compare(rv, cv[7:0]);
        reg_read(`CSD_ADDR_T3_RLD_HI, rv);
        compare(rv, cv[15:8]);
        // Timer three counts system clock enables once it runs.
        reg_write(`CSD_ADDR_T3_CNT_LO, 8'h00);
        reg_write(`CSD_ADDR_T3_CNT_HI, 8'h00);
        reg_write(`CSD_ADDR_T3_CTRL, 8'h01);
        run_ticks(40, 1'b1, 1'b0);
        reg_read(`CSD_ADDR_T3_CNT_LO, rv);
        compare(rv, 16'(hf_n));
        // Watchdog keeps the LF oscillator on with its enable bit clear.
        reg_write(`CSD_ADDR_LF_CTRL, 8'h00);
        compare(lf_osc_run, 1'b0);
        wdt_active <= 1'b1;
        @(posedge sys_clk);
        #1 compare(lf_osc_run, 1'b1);
        complete_run();
    end
endmodule : system_clock_select_divider_tb
